// File: hdl/vbi_board_if.sv
// Backplane board interface: utility, arbiter, master, slave, interrupts
// Overview of operation
// (RQ1) Drive backplane clock from oscillator, removable
// (RQ2) Assert AC-fail during power-on reset
// (RQ3) Assert system reset during processor reset
// (RQ4) Reset master drives bus reset, ignores others
// (RQ5) Reset slave: bus reset acts as power-on
// (RQ6) Watch level 3 only, pass grant on
// (RQ7) Keep bus until another master requests
// (RQ8) Request bus when CPU selects backplane
// (RQ9) Slave answers DTACK or BERR; latched, qualified
// (RQ10) Freeze and rerun if access exceeds 2 usec
// (RQ11) Eight slow edges close response latch
// (RQ12) Two more edges trigger freeze and rerun
// (RQ13) Hold bus controls, data, address while frozen
// (RQ14) Rerun counter times out at 128
// (RQ15) Pending slave access forces CPU rerun
// (RQ16) Rerun request reclocked before bus error/halt
// (RQ17) Slave hit: base, AM4/5, no IACK, strobes
// (RQ18) Slave-pending rising edge raises transfer request
// (RQ19) Buffer write data, register read data
// (RQ20) Enable trailing edge sets BERR or DTACK
// (RQ21) Pending holds until strobes drop, clears responses
// (RQ22) No bus interrupts; enabled levels priority-encoded
// (RQ23) IACK samples pending level, picks autovector
// (RQ24) Timeout ends access with bus error
//
// Our own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ns
module vbi_board_if
   import vbi_pkg::*;
(
   input  wire logic        clk_i,              // 100 MHz clock
   input  wire logic        rst_i,              // Sync reset, high
   input  wire logic [7:0]  wb_adr_i,           // Wishbone byte address
   input  wire logic [31:0] wb_dat_i,           // Wishbone write data
   output logic      [31:0] wb_dat_o,           // Wishbone read data
   input  wire logic [3:0]  wb_sel_i,           // Wishbone byte enables
   input  wire logic        wb_we_i,            // Wishbone write
   input  wire logic        wb_cyc_i,           // Wishbone cycle
   input  wire logic        wb_stb_i,           // Wishbone strobe
   output logic             wb_ack_o,           // Wishbone acknowledge
   input  wire logic        osc_sixteen_mhz_i,  // 16 MHz oscillator
   input  wire logic        por_i,              // Power-on reset
   input  wire logic        wdog_rst_i,         // Watchdog reset
   input  wire logic        cpu_rst_i,          // Processor reset
   output logic             local_reset_o,      // Reset to local devices
   output logic             sysclk_o,           // Backplane clock
   output logic             acfail_oe_n_o,      // AC-fail pull, low=drive
   output logic             sysreset_oe_n_o,    // Bus reset pull
   input  wire logic        backplane_reset_in_i, // Bus reset seen
   input  wire logic        br3_i,              // Level 3 request line
   output logic             br3_oe_n_o,         // Level 3 request pull
   input  wire logic        bg3in_i,            // Grant in
   output logic             bg3out_o,           // Grant out
   output logic             board_owns_bus_o,   // Mastership held
   input  wire logic        backplane_select_i, // CPU selects backplane
   input  wire logic        cpu_state_four_i,   // CPU state 4
   input  wire logic        cpu_iack_i,         // Function code 7
   input  wire logic [23:0] cpu_addr_i,         // CPU address
   input  wire logic [15:0] cpu_wdata_i,        // CPU write data
   input  wire logic        cpu_write_i,        // CPU write
   input  wire logic        slow_clk_i,         // Slow rerun count clock
   input  wire logic        dtack_i,            // Bus DTACK seen
   input  wire logic        berr_i,             // Bus BERR seen
   output logic             cpu_dtack_o,        // Cycle done to CPU
   output logic             cpu_berr_o,         // Bus error to CPU
   output logic             cpu_halt_o,         // Halt, with berr=rerun
   output logic             freeze_o,           // Bus side frozen
   output logic             m_as_oe_n_o,        // Master strobe pull
   output logic [23:0]      m_addr_o,           // Master address
   output logic [15:0]      m_wdata_o,          // Master write data
   output logic             m_write_o,          // Master direction
   input  wire logic [3:0]  vme_addr_hi_i,      // Bus A20..A23
   input  wire logic        am4_i,              // Address modifier 4
   input  wire logic        am5_i,              // Address modifier 5
   input  wire logic        vme_iack_i,         // Bus IACK
   input  wire logic        vme_as_i,           // Bus address strobe
   input  wire logic        vme_ds_i,           // Either data strobe
   input  wire logic [15:0] vme_data_i,         // Bus data in
   output logic [15:0]      vme_data_o,         // Bus data out
   output logic [15:0]      local_wdata_o,      // Slave write to local
   output logic             external_transfer_request_o, // To DMA ctl
   input  wire logic        external_transfer_enable_i,  // From DMA ctl
   input  wire logic        local_berr_i,       // Local bus error
   input  wire logic [15:0] mem_rd_data_i,      // Local read data
   output logic             slave_ack_oe_n_o,   // DTACK pull
   output logic             slave_error_oe_n_o, // BERR pull
   input  wire logic [7:1]  vme_irq_i,          // Bus irq, high=pending
   output logic [2:0]       encoded_bus_irq_level_o, // To CPU merge
   output logic             autovector_select_o // Autovector
);
   vbi_state_t s_r;
   vbi_state_t s_nxt;
   logic       master;
   logic       slave_hit;
   logic       slow_fall;
   logic       want_bus;
   logic       resp_seen;
   logic       latch_open;
   logic       retry_trigger;
   logic       sel_rise;
   logic [7:1] irq_en;

   function automatic logic [2:0] prio_enc(input logic [7:1] req);
      prio_enc = 3'h0;
      for (int i = 1; i < 8; i++) begin
         if (req[i]) begin
            prio_enc = 3'(i);
         end
      end
   endfunction

   assign master     = s_r.ctrl[CTRL_MASTER];
   assign irq_en     = s_r.ctrl[CTRL_IRQEN_LO +: 7];
   assign slow_fall  = s_r.slow_prev & ~slow_clk_i;
   assign sel_rise   = backplane_select_i & ~s_r.sel_prev;
   assign latch_open = s_r.slow_cnt < SLOW_LATCH_CNT;
   assign resp_seen  = s_r.resp_dtack | s_r.resp_berr;
   assign want_bus   = backplane_select_i & ~s_r.slave_pend;
   assign retry_trigger = s_r.run & (s_r.slow_cnt == SLOW_TRIG_CNT)
                        & ~resp_seen & ~s_r.frozen;            // [RQ12]
   assign slave_hit  = (vme_addr_hi_i == s_r.ctrl[CTRL_BASE_LO +: 4])
                     & am4_i & am5_i & ~vme_iack_i
                     & (s_r.arb != ARB_OWN)
                     & vme_as_i & vme_ds_i;                    // [RQ17]

   always_comb begin
      s_nxt = s_r;
      s_nxt.sel_prev  = backplane_select_i;
      s_nxt.s4_prev   = cpu_state_four_i;
      s_nxt.slow_prev = slow_clk_i;
      s_nxt.en_prev   = external_transfer_enable_i;

      // Register slave: answer in the cycle after the strobe
      s_nxt.wb_ack = wb_cyc_i & wb_stb_i & ~s_r.wb_ack;
      if (wb_cyc_i & wb_stb_i & ~s_r.wb_ack) begin
         s_nxt.wb_dat = 32'h0000_0000;
         if (wb_adr_i == ADR_CTRL) begin
            s_nxt.wb_dat = s_r.ctrl;
            if (wb_we_i) begin
               for (int b = 0; b < 4; b++) begin
                  if (wb_sel_i[b]) begin
                     s_nxt.ctrl[8*b +: 8] = wb_dat_i[8*b +: 8];
                  end
               end
            end
         end else if (wb_adr_i == ADR_STATUS) begin
            s_nxt.wb_dat = {16'h0000, s_r.rerun_cnt, 2'b00,
                            s_r.slave_pend, s_r.timeout, s_r.frozen,
                            s_r.arb};
         end
      end

      // Single-level arbiter, release on request
      unique case (s_r.arb)
         ARB_IDLE: begin
            if (want_bus) begin
               s_nxt.arb = ARB_REQ;                            // [RQ8]
            end
         end
         ARB_REQ: begin
            if (bg3in_i) begin
               s_nxt.arb = ARB_OWN;                            // [RQ6]
            end else if (!want_bus) begin
               s_nxt.arb = ARB_IDLE;
            end
         end
         ARB_OWN: begin
            // Frozen cycles may yield; the rerun resumes later
            if (br3_i && (!backplane_select_i || s_r.frozen)) begin
               s_nxt.arb = ARB_IDLE;                           // [RQ7]
            end
         end
         default: s_nxt.arb = ARB_IDLE;
      endcase

      // Master cycle latch; frozen copy stays put
      if (backplane_select_i && !s_r.frozen) begin
         s_nxt.m_addr  = cpu_addr_i;
         s_nxt.m_wdata = cpu_wdata_i;
         s_nxt.m_write = cpu_write_i;
      end                                                      // [RQ13]

      // Rerun counter, started at state four
      if (cpu_state_four_i && !s_r.s4_prev && backplane_select_i) begin
         s_nxt.run      = 1'b1;
         s_nxt.slow_cnt = 4'h0;
      end else if (s_r.run && slow_fall &&
                   s_r.slow_cnt != SLOW_TRIG_CNT) begin
         s_nxt.slow_cnt = s_r.slow_cnt + 4'h1;                 // [RQ11]
      end
      if (s_r.run && slow_fall && s_r.slow_cnt == SLOW_LATCH_CNT - 4'h1)
      begin
         s_nxt.rerun_cnt = s_r.rerun_cnt + 8'h01;              // [RQ14]
      end
      if (s_r.rerun_cnt == RERUN_LIMIT) begin
         s_nxt.timeout = 1'b1;                                 // [RQ14]
      end

      // Response latch open only until the count reaches eight
      if (s_r.run && latch_open && (s_r.arb == ARB_OWN)) begin
         s_nxt.resp_dtack = s_r.resp_dtack | (dtack_i & ~berr_i);
         s_nxt.resp_berr  = s_r.resp_berr | berr_i;            // [RQ9]
      end

      s_nxt.rerun_req = 1'b0;
      if (retry_trigger) begin
         s_nxt.frozen    = 1'b1;                               // [RQ10]
         s_nxt.rerun_req = ~s_r.timeout;
      end
      if (backplane_select_i && s_r.slave_pend && !resp_seen) begin
         s_nxt.rerun_req = 1'b1;                               // [RQ15]
      end
      s_nxt.rerun_sync = s_r.rerun_req;                        // [RQ16]

      if (!backplane_select_i) begin
         s_nxt.run        = 1'b0;
         s_nxt.resp_dtack = 1'b0;
         s_nxt.resp_berr  = 1'b0;
      end
      if (sel_rise) begin
         s_nxt.frozen = 1'b0;                                  // [RQ13]
      end
      if (resp_seen) begin
         s_nxt.rerun_cnt = 8'h00;
         s_nxt.timeout   = 1'b0;
      end

      // Slave side
      s_nxt.slave_pend = slave_hit;                            // [RQ21]
      if (external_transfer_enable_i) begin
         s_nxt.xfer_req = 1'b0;
         s_nxt.rd_data  = mem_rd_data_i;                       // [RQ19]
      end
      if (slave_hit && !s_r.slave_pend) begin
         s_nxt.xfer_req = 1'b1;                                // [RQ18]
      end
      if (s_r.en_prev && !external_transfer_enable_i) begin
         s_nxt.sl_err = local_berr_i;                          // [RQ20]
         s_nxt.sl_ack = ~local_berr_i;
      end
      if (!slave_hit) begin
         s_nxt.sl_err = 1'b0;                                  // [RQ21]
         s_nxt.sl_ack = 1'b0;
      end

      // Interrupt path
      s_nxt.ipl = prio_enc(vme_irq_i & irq_en);                // [RQ22]
      if (cpu_state_four_i && !s_r.s4_prev && cpu_iack_i) begin
         s_nxt.autov = ~(vme_irq_i[cpu_addr_i[3:1]]
                         & irq_en[cpu_addr_i[3:1]]
                         & (cpu_addr_i[3:1] != 3'h0))
                     | ~cpu_addr_i[19];                        // [RQ23]
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r      <= '0;
         s_r.arb  <= ARB_IDLE;
         s_r.ctrl <= CTRL_RST;
         s_r.autov <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Clock drive is a plain gate; the oscillator is not our clock
   assign sysclk_o        = osc_sixteen_mhz_i
                          & s_r.ctrl[CTRL_SYSCLK];             // [RQ1]
   assign acfail_oe_n_o   = ~por_i;                            // [RQ2]
   assign sysreset_oe_n_o = ~(master & (por_i | wdog_rst_i
                                        | cpu_rst_i));   // [RQ3] [RQ4]
   assign local_reset_o   = por_i
                          | (~master & backplane_reset_in_i);  // [RQ5]
   assign br3_oe_n_o      = ~(s_r.arb == ARB_REQ);             // [RQ8]
   assign bg3out_o        = bg3in_i & (s_r.arb == ARB_IDLE);   // [RQ6]
   assign board_owns_bus_o = s_r.arb == ARB_OWN;
   assign m_as_oe_n_o     = ~((s_r.arb == ARB_OWN)
                              & (backplane_select_i | s_r.frozen));
   assign m_addr_o        = s_r.m_addr;
   assign m_wdata_o       = s_r.m_wdata;
   assign m_write_o       = s_r.m_write;
   assign freeze_o        = s_r.frozen;
   assign cpu_dtack_o     = s_r.resp_dtack;
   assign cpu_berr_o      = s_r.resp_berr | s_r.rerun_sync
                          | (s_r.frozen & s_r.timeout);        // [RQ24]
   assign cpu_halt_o      = s_r.rerun_sync;                    // [RQ16]
   assign local_wdata_o   = vme_data_i;                        // [RQ19]
   assign vme_data_o      = s_r.rd_data;
   assign external_transfer_request_o = s_r.xfer_req;
   assign slave_ack_oe_n_o   = ~s_r.sl_ack;                    // [RQ20]
   assign slave_error_oe_n_o = ~s_r.sl_err;
   assign encoded_bus_irq_level_o = s_r.ipl;
   assign autovector_select_o = s_r.autov;
   assign wb_ack_o        = s_r.wb_ack;
   assign wb_dat_o        = s_r.wb_dat;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence seq_trigger;
      retry_trigger;
   endsequence
   sequence seq_rerun_out;
      ##2 (cpu_berr_o && cpu_halt_o);
   endsequence

   AST_RERUN_PATH: assert property ((seq_trigger
      ##0 !s_r.timeout) |-> seq_rerun_out) // [RQ16]
      else $error("rerun not driven two cycles after trigger");
   AST_FREEZE: assert property (retry_trigger |=> freeze_o) // [RQ10]
      else $error("freeze missing after trigger");
   AST_HOLD_ADDR: assert property (freeze_o && !sel_rise
      |=> $stable(m_addr_o) && $stable(m_wdata_o)) // [RQ13]
      else $error("address moved while frozen");
   AST_TRIG_COUNT: assert property (retry_trigger
      |-> s_r.slow_cnt == 4'hA && !resp_seen) // [RQ12]
      else $error("trigger at wrong count");
   AST_LATCH_CLOSED: assert property (!latch_open && !resp_seen
      && backplane_select_i |=> !resp_seen) // [RQ11]
      else $error("response taken after latch closed");
   AST_TIMEOUT: assert property (s_r.rerun_cnt == 8'h80
      |=> s_r.timeout || resp_seen) // [RQ14]
      else $error("timeout not raised at 128");
   AST_NO_SELF_GRANT: assert property (s_r.arb == ARB_IDLE
      && bg3in_i |-> bg3out_o) // [RQ6]
      else $error("grant not passed on");
   AST_KEEP_BUS: assert property (board_owns_bus_o && !br3_i
      |=> board_owns_bus_o) // [RQ7]
      else $error("bus released without request");
   AST_XFER_REQ: assert property (slave_hit && !s_r.slave_pend
      |=> external_transfer_request_o) // [RQ18]
      else $error("transfer request not raised");
   AST_SLAVE_CLR: assert property (!slave_hit
      |=> slave_ack_oe_n_o && slave_error_oe_n_o) // [RQ21]
      else $error("slave response not cleared");
   AST_SLAVE_RESP: assert property ($fell(external_transfer_enable_i)
      && slave_hit |=> slave_error_oe_n_o == !$past(local_berr_i)
      && slave_ack_oe_n_o == $past(local_berr_i)) // [RQ20]
      else $error("wrong slave response");
   AST_DEADLOCK: assert property (backplane_select_i && s_r.slave_pend
      && !resp_seen |-> ##2 cpu_halt_o) // [RQ15]
      else $error("deadlock rerun missing");
   AST_NO_SLAVE_OWN: assert property (board_owns_bus_o
      |-> !slave_hit) // [RQ17]
      else $error("slave hit while master");
endmodule

// File: hdl/vbi_pkg.sv
// Constants and types for the backplane board interface
package vbi_pkg;
   localparam logic [7:0]  ADR_CTRL       = 8'h00;
   localparam logic [7:0]  ADR_STATUS     = 8'h04;
   localparam logic [31:0] CTRL_RST       = 32'h0000_0003;
   localparam int          CTRL_MASTER    = 0;
   localparam int          CTRL_SYSCLK    = 1;
   localparam int          CTRL_BASE_LO   = 8;
   localparam int          CTRL_IRQEN_LO  = 16;
   localparam logic [3:0]  SLOW_LATCH_CNT = 4'h8;
   localparam logic [3:0]  SLOW_TRIG_CNT  = 4'hA;
   localparam logic [7:0]  RERUN_LIMIT    = 8'h80;

   typedef enum logic [2:0] {
      ARB_IDLE = 3'b001,
      ARB_REQ  = 3'b010,
      ARB_OWN  = 3'b100
   } vbi_arb_t;

   typedef struct packed {
      vbi_arb_t    arb;
      logic        wb_ack;
      logic [31:0] wb_dat;
      logic [31:0] ctrl;
      logic        sel_prev;
      logic        s4_prev;
      logic        slow_prev;
      logic        run;
      logic [3:0]  slow_cnt;
      logic        resp_dtack;
      logic        resp_berr;
      logic        rerun_req;
      logic        rerun_sync;
      logic        frozen;
      logic [7:0]  rerun_cnt;
      logic        timeout;
      logic [23:0] m_addr;
      logic [15:0] m_wdata;
      logic        m_write;
      logic        slave_pend;
      logic        xfer_req;
      logic        en_prev;
      logic        sl_ack;
      logic        sl_err;
      logic [15:0] rd_data;
      logic        autov;
      logic [2:0]  ipl;
   } vbi_state_t;
endpackage

// File: verification/vbi_far_end.sv
// Far-side model: level-3 grant, a responding slave and a rival master
`timescale 1ns/1ns
module vbi_far_end (
   input  wire logic       clk_i,      // Bench clock
   input  wire logic       rst_i,      // Sync reset, high
   input  wire logic       br3_oe_n_i, // Board request pull
   input  wire logic       as_oe_n_i,  // Board strobe pull
   input  wire logic [1:0] mode_i,     // 0 silent, 1 ack, 2 error
   input  wire logic [3:0] delay_i,    // Answer delay, cycles
   input  wire logic       rival_i,    // Another master wants the bus
   output logic            br3_o,      // Request line level
   output logic            bg3in_o,    // Grant into the board
   output logic            dtack_o,    // Slave ack seen by board
   output logic            berr_o      // Slave error seen by board
);
   logic [3:0] cnt_r;

   // Wired request line, high while anyone pulls it
   assign br3_o = rival_i | !br3_oe_n_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r   <= 4'h0;
         bg3in_o <= 1'h0;
         dtack_o <= 1'h0;
         berr_o  <= 1'h0;
      end else begin
         bg3in_o <= br3_o;
         if (as_oe_n_i) begin
            // Pulled-up lines read inactive once the strobe is gone
            cnt_r   <= 4'h0;
            dtack_o <= 1'h0;
            berr_o  <= 1'h0;
         end else if (cnt_r < delay_i) begin
            cnt_r <= cnt_r + 4'h1;
         end else begin
            dtack_o <= mode_i == 2'h1;
            berr_o  <= mode_i == 2'h2;
         end
      end
   end
endmodule

// File: verification/tb.sv
// Self-checking bench for the backplane board interface
`timescale 1ns/1ns
module tb;
   import vbi_pkg::*;
   logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
   logic        osc_sixteen_mhz_i, por_i, wdog_rst_i, cpu_rst_i, sysclk_o;
   logic        local_reset_o, acfail_oe_n_o, sysreset_oe_n_o, br3_i;
   logic        backplane_reset_in_i, br3_oe_n_o, bg3in_i, bg3out_o;
   logic        board_owns_bus_o, backplane_select_i, cpu_state_four_i;
   logic        cpu_iack_i, cpu_write_i, slow_clk_i, dtack_i, berr_i;
   logic        cpu_dtack_o, cpu_berr_o, cpu_halt_o, freeze_o, m_write_o;
   logic        m_as_oe_n_o, am4_i, am5_i, vme_iack_i, vme_as_i, vme_ds_i;
   logic        external_transfer_request_o, external_transfer_enable_i;
   logic        local_berr_i, slave_ack_oe_n_o, slave_error_oe_n_o;
   logic        autovector_select_o, rival, a19;
   logic [1:0]  mode;
   logic [2:0]  encoded_bus_irq_level_o, lv;
   logic [3:0]  wb_sel_i, vme_addr_hi_i, dly, sc;
   logic [7:0]  wb_adr_i;
   logic [7:1]  vme_irq_i;
   logic [15:0] cpu_wdata_i, m_wdata_o, vme_data_i, vme_data_o;
   logic [15:0] local_wdata_o, mem_rd_data_i;
   logic [23:0] cpu_addr_i, m_addr_o;
   logic [31:0] wb_dat_i, wb_dat_o, ctrl, q;
   int          n_fail, checked, cyc;

   vbi_board_if u_vbi_board_if (
      .clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_sel_i, .wb_we_i,
      .wb_cyc_i, .wb_stb_i, .wb_ack_o, .osc_sixteen_mhz_i, .por_i,
      .wdog_rst_i, .cpu_rst_i, .local_reset_o, .sysclk_o, .acfail_oe_n_o,
      .sysreset_oe_n_o, .backplane_reset_in_i, .br3_i, .br3_oe_n_o,
      .bg3in_i, .bg3out_o, .board_owns_bus_o, .backplane_select_i,
      .cpu_state_four_i, .cpu_iack_i, .cpu_addr_i, .cpu_wdata_i,
      .cpu_write_i, .slow_clk_i, .dtack_i, .berr_i, .cpu_dtack_o,
      .cpu_berr_o, .cpu_halt_o, .freeze_o, .m_as_oe_n_o, .m_addr_o,
      .m_wdata_o, .m_write_o, .vme_addr_hi_i, .am4_i, .am5_i, .vme_iack_i,
      .vme_as_i, .vme_ds_i, .vme_data_i, .vme_data_o, .local_wdata_o,
      .external_transfer_request_o, .external_transfer_enable_i,
      .local_berr_i, .mem_rd_data_i, .slave_ack_oe_n_o, .slave_error_oe_n_o,
      .vme_irq_i, .encoded_bus_irq_level_o, .autovector_select_o);

   vbi_far_end u_vbi_far_end (.clk_i, .rst_i, .br3_oe_n_i(br3_oe_n_o),
      .as_oe_n_i(m_as_oe_n_o), .mode_i(mode), .delay_i(dly), .rival_i(rival),
      .br3_o(br3_i), .bg3in_o(bg3in_i), .dtack_o(dtack_i), .berr_o(berr_i));

   always #5 clk_i = ~clk_i;

   always @(posedge clk_i) begin
      sc <= sc + 4'h1;
      slow_clk_i <= sc[3]; // Falls once every 16 cycles
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         close_out();
      end
   end

   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e,
                      input string m);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask

   // Classic cycle; entered right after an edge
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      step(1);
      while (wb_ack_o !== 1'h1) begin
         step(1);
      end
      q = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      step(1);
   endtask

   function automatic logic [2:0] exp_ipl(input logic [7:1] p);
      exp_ipl = 3'h0;
      for (int l = 1; l < 8; l++) begin
         if (p[l]) begin
            exp_ipl = 3'(l);
         end
      end
   endfunction

   // Master access answered by the far side per md; 0 leaves it unanswered
   task automatic macc(input logic [1:0] md);
      logic [23:0] a;
      logic [15:0] d;
      logic        w;
      int          n;
      a = 24'($urandom);
      w = 1'($urandom);
      d = 16'($urandom);
      n = 0;
      mode <= md;
      dly <= 4'($urandom_range(5));
      cpu_addr_i <= a;
      cpu_write_i <= w;
      cpu_wdata_i <= d;
      backplane_select_i <= 1'h1;
      step(1);
      cpu_state_four_i <= 1'h1;
      while ({cpu_dtack_o, cpu_berr_o} === 2'h0) begin
         step(1);
         n++;
      end
      if (md == 2'h0) begin
         chk({cpu_berr_o, cpu_halt_o}, 2'h3,
             "rerun");
         chk(n >= 140 && n <= 175, 1'h1, "late");
         cpu_addr_i <= ~a;
         step(2);
         chk(freeze_o, 1'h1, "frz");
         chk({m_addr_o, m_write_o, m_wdata_o}, {a, w, d},
             "hold");
      end else begin
         chk({cpu_dtack_o, cpu_berr_o}, {md == 2'h1, md == 2'h2},
             "resp");
         chk({m_addr_o, board_owns_bus_o, m_as_oe_n_o}, {a, 2'h2},
             "own");
      end
      backplane_select_i <= 1'h0;
      cpu_state_four_i <= 1'h0;
      step(2);
   endtask

   // Slave access; k breaks one hit term, sel makes the CPU collide
   task automatic sacc(input logic [2:0] k, input logic sel);
      logic [15:0] d, r;
      logic        e;
      int          n;
      d = 16'($urandom);
      r = 16'($urandom);
      e = 1'($urandom);
      n = 0;
      vme_addr_hi_i <= ctrl[11:8] ^ {3'h0, k == 3'h1};
      am4_i <= k != 3'h2;
      am5_i <= k != 3'h3;
      vme_iack_i <= k == 3'h4;
      {vme_as_i, vme_ds_i} <= 2'h3;
      vme_data_i <= d;
      mem_rd_data_i <= r;
      local_berr_i <= e;
      step(4);
      chk(external_transfer_request_o, k == 3'h0, "hit");
      chk(local_wdata_o, d, "wdat");
      if (sel) begin
         {backplane_select_i, cpu_state_four_i} <= 2'h3;
         while (cpu_halt_o !== 1'h1 && n < 20) begin
            step(1);
            n++;
         end
         chk(cpu_halt_o, 1'h1, "lock");
         {backplane_select_i, cpu_state_four_i} <= 2'h0;
      end else if (k == 3'h0) begin
         external_transfer_enable_i <= 1'h1;
         step(2);
         chk(external_transfer_request_o, 1'h0, "rqclr");
         external_transfer_enable_i <= 1'h0;
         step(3);
         chk({slave_ack_oe_n_o, slave_error_oe_n_o}, {e, !e},
             "sresp");
         chk(vme_data_o, r, "rdat");
      end
      {vme_as_i, vme_ds_i} <= 2'h0;
      step(3);
      chk({slave_ack_oe_n_o, slave_error_oe_n_o}, 2'h3, "rel");
   endtask

   task automatic close_out();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      {clk_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_sel_i, wb_adr_i, wb_dat_i,
       osc_sixteen_mhz_i, por_i, wdog_rst_i, cpu_rst_i, backplane_reset_in_i,
       backplane_select_i, cpu_state_four_i, cpu_iack_i, cpu_addr_i,
       cpu_wdata_i, cpu_write_i, vme_addr_hi_i, am4_i, am5_i, vme_iack_i,
       vme_as_i, vme_ds_i, vme_data_i, external_transfer_enable_i,
       local_berr_i, mem_rd_data_i, vme_irq_i, mode, dly, rival, sc,
       slow_clk_i} = '0;
      rst_i = 1'h1;
      void'($urandom(25));
      step(6);
      rst_i <= 1'h0;
      step(1);
      wb(1'h0, ADR_CTRL, '0);
      chk(q, CTRL_RST, "ctrl0");
      wb(1'h0, 8'hFC, '0);
      chk(q, '0, "hole");
      ctrl = {9'h000, 7'($urandom), 4'h0, 4'($urandom), 8'h03};
      wb(1'h1, ADR_CTRL, ctrl);
      wb(1'h1, 8'hFC, ~ctrl);
      wb(1'h0, ADR_CTRL, '0);
      chk(q, ctrl, "ctrl");
      $display("test regs done");
      for (int i = 0; i < 16; i++) begin
         if (i == 8) begin
            ctrl[1:0] = 2'h0;
            wb(1'h1, ADR_CTRL, ctrl);
         end
         {osc_sixteen_mhz_i, por_i, wdog_rst_i, cpu_rst_i,
          backplane_reset_in_i} <= 5'($urandom);
         step(1);
         chk(sysclk_o, osc_sixteen_mhz_i & ctrl[1], "clk");
         chk(acfail_oe_n_o, !por_i, "acf");
         chk(sysreset_oe_n_o, !(ctrl[0] & (por_i | wdog_rst_i | cpu_rst_i)),
             "srst");
         chk(local_reset_o, por_i | (!ctrl[0] & backplane_reset_in_i),
             "lrst");
      end
      {osc_sixteen_mhz_i, por_i, wdog_rst_i, cpu_rst_i} <= 4'h0;
      ctrl[1:0] = 2'h3;
      wb(1'h1, ADR_CTRL, ctrl);
      $display("test utility done");
      macc(2'h1);
      macc(2'h2);
      macc(2'h0);
      macc(2'h1);
      step(20);
      chk(board_owns_bus_o, 1'h1, "keep");
      rival <= 1'h1;
      step(4);
      chk({board_owns_bus_o, bg3out_o}, 2'h1, "yield");
      rival <= 1'h0;
      step(2);
      $display("test master done");
      sacc(3'h0, 1'h0);
      for (int i = 0; i < 10; i++) begin
         sacc(3'($urandom_range(4)), 1'h0);
      end
      $display("test slave done");
      for (int i = 0; i < 8; i++) begin
         lv = 3'($urandom_range(7, 1));
         a19 = 1'($urandom);
         vme_irq_i <= 7'($urandom);
         cpu_iack_i <= 1'h1;
         cpu_addr_i <= {4'h0, a19, 15'h0000, lv, 1'h0};
         step(1);
         cpu_state_four_i <= 1'h1;
         step(3);
         chk(encoded_bus_irq_level_o, exp_ipl(vme_irq_i & ctrl[22:16]),
             "ipl");
         chk(autovector_select_o, !(a19 & vme_irq_i[lv] & ctrl[15 + lv]),
             "autov");
         {cpu_state_four_i, cpu_iack_i} <= 2'h0;
         step(1);
      end
      $display("test irq done");
      sacc(3'h0, 1'h1);
      $display("test deadlock done");
      close_out();
   end
endmodule
